// ### hw/ttw_defs.svh
`ifndef TTW_DEFS_SVH
`define TTW_DEFS_SVH

// Register byte offsets
`define TTW_OFS_CONFIG   8'h00
`define TTW_OFS_PRESCALE 8'h04
`define TTW_OFS_PERIOD   8'h08
`define TTW_OFS_CSR      8'h0C
`define TTW_OFS_WDCOUNT  8'h10
`define TTW_OFS_WDKEY    8'h14

// Configuration bit positions
`define TTW_CFG_LOCK_CFG 0
`define TTW_CFG_LOCK_PRE 1
`define TTW_CFG_LOCK_TCK 2
`define TTW_CFG_LOCK_WD  3
`define TTW_CFG_CLK_SEL  4
`define TTW_CFG_KEY_EN   5

// Control/status bit positions
`define TTW_CSR_RESTART 0
`define TTW_CSR_TC      1
`define TTW_CSR_IRQ_EN  2

// Reset values and constants
`define TTW_CFG_RST    6'h00
`define TTW_PRE_RST    3'h0
`define TTW_PERIOD_RST 16'hFFFF
`define TTW_WDOG_RELOAD_COUNT_RST  8'h0F
`define TTW_SVC_KEY    8'h5C
`endif

// ### hw/ttw_pkg.sv
package ttw_pkg;
  // Power mode of the surrounding device
  typedef enum logic [1:0] {
    TTW_ACTIVE = 2'h0,
    TTW_IDLE   = 2'h1,
    TTW_PSAVE  = 2'h2,
    TTW_HALT   = 2'h3
  } ttw_pmode_t;

  // Watchdog run state
  typedef enum logic [1:0] {
    TTW_WD_OFF = 2'h1,
    TTW_WD_RUN = 2'h2
  } ttw_wd_state_t;
endpackage

// ### hw/ttw_core.sv
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "ttw_defs.svh"
module ttw_core (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             srst,
  // APB slave
  input  wire logic [7:0]       paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Device side
  input  wire logic             low_speed_clock,
  input  wire ttw_pkg::ttw_pmode_t pwr_mode,
  output logic                  tick_out_pulse,
  output logic                  tick_irq,
  output logic                  wdog_reset_req
);
  import ttw_pkg::*;

  // Overview of the block
  // All slow activity is derived from the synchronised slow clock pin.
  // The pin passes two flip-flops; a third one gives a rising-edge pulse.
  // That pulse is one core cycle wide and marks one slow clock edge.
  // The slow clock must stay well below a quarter of the core clock.
  // Otherwise slow edges are lost and every period stretches.
  //
  // Prescaler
  // A free running five bit counter advances on each slow edge.
  // The divider code selects how many low bits must all be set.
  // Code 0 passes every slow edge, code 5 every thirty-second one.
  // Codes 6 and 7 behave as code 5; they are not meant to be used.
  // A change of code takes effect at once, so one period may be short.
  //
  // Tick timer
  // The sixteen bit count moves only on a tick-in edge.
  // At zero, or with restart pending, it loads the preset instead.
  // A new count of zero raises the tick output until the next edge.
  // The same edge sets the terminal flag and may pulse the interrupt.
  // A preset written while counting is used at the next reload only.
  // A preset of zero gives a zero event on every tick-in edge.
  //
  // Restart bit
  // A written one stays pending until the next tick-in edge.
  // That edge reloads the count and clears the pending bit.
  // A write in the very cycle of an edge waits for the following one.
  //
  // Terminal flag
  // Set by a zero event, cleared by a status read.
  // When both fall in one cycle the set wins, so no event is lost.
  // The read still returns the old value, taken before the clear.
  //
  // Watchdog clock
  // Either every tick-in edge or every zero event of the timer.
  // The choice is one sticky bit, so it cannot be undone by software.
  //
  // Watchdog start
  // The watchdog stays off after reset and raises no error then.
  // A count write starts it; a correct key write starts it too.
  // A key write with key service disabled is ignored entirely.
  // Once running only a reset stops it.
  //
  // Watchdog service
  // Plain mode: a count write reloads the counter with its data.
  // Key mode: the key value reloads the stored count value.
  // Key mode: any other key value is an error at once.
  // In key mode a count write reloads but is not counted as service.
  //
  // Watchdog errors
  // Late: a watchdog clock arrives with the counter at zero.
  // Often: a second service before the next watchdog clock.
  // A service in the cycle of a watchdog clock opens the new period.
  // After a late error the counter stays at zero.
  // Errors then repeat on every watchdog clock until a reload or reset.
  // Each error is a single cycle request on the reset output.
  //
  // Register access
  // Every transfer has exactly one wait state.
  // Read data and the error flag stand only with pready.
  // Unmapped addresses answer with an error and read zero.
  // Outside active mode only the key register is reachable.
  // A locked register ignores writes and reads back zero.
  // Write-only registers read back zero as well.
  //
  // Configuration register
  // Every bit is set by writing one and cleared only by reset.
  // Bits 0 to 3 lock registers; bit 0 also locks itself.
  // Bit 4 selects the watchdog clock, bit 5 enables key service.
  //
  // Power modes
  // Idle and power save keep every counter running.
  // Halt masks the slow edge, so all counters freeze in place.
  // Leaving halt resumes from the frozen state without a jump.
  // The synchroniser keeps running so no stale edge is replayed.
  //
  // Software hints
  // After a restart or a count write allow a few slow periods
  // before power save, or the write may not have settled yet.
  //
  // Outputs
  // Every output comes straight from a flip-flop of this clock.

  // Prescaler mask for a divider code
  function automatic logic [4:0] div_mask(input logic [2:0] code);
    case (code)
      3'h0:    div_mask = 5'h00;
      3'h1:    div_mask = 5'h01;
      3'h2:    div_mask = 5'h03;
      3'h3:    div_mask = 5'h07;
      3'h4:    div_mask = 5'h0F;
      default: div_mask = 5'h1F;
    endcase
  endfunction

  // Address compare
  function automatic logic is_ofs(input logic [7:0] a,
                                  input logic [7:0] o);
    is_ofs = (a == o);
  endfunction

  logic          ls_s1_reg;
  logic          ls_s2_reg;
  logic          ls_s3_reg;
  logic          pready_reg;
  logic          pslverr_reg;
  logic [31:0]   prdata_reg;
  logic [5:0]    cfg_reg;
  logic [2:0]    div_code_reg;
  logic [15:0]   preset_reg;
  logic          irq_en_reg;
  logic          restart_reg;
  logic          tc_reg;
  logic [4:0]    pre_cnt_reg;
  logic [15:0]   count_reg;
  logic          tick_out_reg;
  logic          tick_irq_reg;
  logic [7:0]    wdog_reload_count_reg;
  logic [7:0]    wd_cnt_reg;
  ttw_wd_state_t wd_state_reg;
  logic          svc_seen_reg;
  logic          wd_err_reg;

  // Slow clock synchroniser and edge detect
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ls_s1_reg <= 1'b0;
      ls_s2_reg <= 1'b0;
      ls_s3_reg <= 1'b0;
    end else begin
      ls_s1_reg <= low_speed_clock;
      ls_s2_reg <= ls_s1_reg;
      ls_s3_reg <= ls_s2_reg;
    end
  end

  // Power mode decode; halt stops every slow event
  wire halted    = (pwr_mode == TTW_HALT);
  wire active    = (pwr_mode == TTW_ACTIVE);
  wire slow_rise = ls_s2_reg & ~ls_s3_reg & ~halted;

  // APB phases
  wire access   = psel & penable;
  wire first_ac = access & ~pready_reg;
  wire commit   = access & pready_reg;
  wire wr       = commit & pwrite;

  // Address decode
  wire sel_cfg  = is_ofs(paddr, `TTW_OFS_CONFIG);
  wire sel_pre  = is_ofs(paddr, `TTW_OFS_PRESCALE);
  wire sel_per  = is_ofs(paddr, `TTW_OFS_PERIOD);
  wire sel_csr  = is_ofs(paddr, `TTW_OFS_CSR);
  wire sel_wdc  = is_ofs(paddr, `TTW_OFS_WDCOUNT);
  wire sel_key  = is_ofs(paddr, `TTW_OFS_WDKEY);
  wire mapped   = sel_cfg | sel_pre | sel_per | sel_csr | sel_wdc
                | sel_key;

  // Mode and lock gating
  wire allowed  = sel_key | (mapped & active);
  wire lk_cfg   = cfg_reg[`TTW_CFG_LOCK_CFG];
  wire lk_pre   = cfg_reg[`TTW_CFG_LOCK_PRE];
  wire lk_tck   = cfg_reg[`TTW_CFG_LOCK_TCK];
  wire lk_wd    = cfg_reg[`TTW_CFG_LOCK_WD];
  wire blocked  = (sel_cfg & lk_cfg) | (sel_pre & lk_pre)
                | ((sel_per | sel_csr) & lk_tck)
                | (sel_wdc & lk_wd);
  wire ok       = allowed & ~blocked;

  // Write strobes
  wire we_cfg   = wr & sel_cfg & ok;
  wire we_pre   = wr & sel_pre & ok;
  wire we_per   = wr & sel_per & ok;
  wire we_csr   = wr & sel_csr & ok;
  wire we_wdc   = wr & sel_wdc & ok;
  wire we_key   = wr & sel_key & ok;
  wire rd_csr   = first_ac & ~pwrite & sel_csr & ok;

  // Read selection; locked or write-only reads give zero
  wire [31:0] rd_value =
      ~ok     ? 32'h0000_0000 :
      sel_cfg ? {26'h000_0000, cfg_reg} :
      sel_pre ? {29'h0000_0000, div_code_reg} :
      sel_per ? {16'h0000, preset_reg} :
      sel_csr ? {29'h0000_0000, irq_en_reg, tc_reg, restart_reg} :
                32'h0000_0000;

  // Bus answer one cycle into the access phase
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= first_ac;
      pslverr_reg <= first_ac & ~allowed;
      prdata_reg  <= (first_ac & ~pwrite) ? rd_value : 32'h0000_0000;
    end
  end

  // Sticky configuration bits
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_reg <= `TTW_CFG_RST;
    end else if (we_cfg) begin
      cfg_reg <= cfg_reg | pwdata[5:0];
    end
  end

  // Prescaler code and timer preset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      div_code_reg <= `TTW_PRE_RST;
      preset_reg   <= `TTW_PERIOD_RST;
    end else begin
      if (we_pre) begin
        div_code_reg <= pwdata[2:0];
      end
      if (we_per) begin
        preset_reg <= pwdata[15:0];
      end
    end
  end

  // Prescaler: tick-in edge every 2^code slow edges, every 32 for codes 5 to 7
  wire [4:0] pmask       = div_mask(div_code_reg);
  wire       tick_in_rise = slow_rise & ((pre_cnt_reg & pmask) == pmask);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pre_cnt_reg <= 5'h00;
    end else if (slow_rise) begin
      pre_cnt_reg <= 5'(pre_cnt_reg + 5'h01);
    end
  end

  // Timer next count and zero event
  wire        t_reload  = restart_reg | (count_reg == 16'h0000);
  wire [15:0] t_next    = t_reload ? preset_reg
                                   : 16'(count_reg - 16'h0001);
  wire        tick_zero = tick_in_rise & (t_next == 16'h0000);

  // Tick timer and tick-out pulse
  always_ff @(posedge core_clk) begin
    if (srst) begin
      count_reg    <= `TTW_PERIOD_RST;
      tick_out_reg <= 1'b0;
    end else if (tick_in_rise) begin
      count_reg    <= t_next;
      tick_out_reg <= (t_next == 16'h0000);
    end
  end

  // Control/status: set of the flag wins over read clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_en_reg   <= 1'b0;
      restart_reg  <= 1'b0;
      tc_reg       <= 1'b0;
      tick_irq_reg <= 1'b0;
    end else begin
      if (we_csr) begin
        irq_en_reg <= pwdata[`TTW_CSR_IRQ_EN];
      end
      restart_reg  <= (we_csr & pwdata[`TTW_CSR_RESTART])
                    | (restart_reg & ~tick_in_rise);
      tc_reg       <= tick_zero | (tc_reg & ~rd_csr);
      tick_irq_reg <= tick_zero & irq_en_reg;
    end
  end

  // Watchdog clock and service decode
  wire wd_sel  = cfg_reg[`TTW_CFG_CLK_SEL];
  wire key_en  = cfg_reg[`TTW_CFG_KEY_EN];
  wire wd_clk  = wd_sel ? tick_in_rise : tick_zero;
  wire key_ok  = (pwdata[7:0] == `TTW_SVC_KEY);
  wire key_hit = we_key & key_en & key_ok;
  wire key_bad = we_key & key_en & ~key_ok;
  wire service = (we_wdc & ~key_en) | key_hit;
  wire reload  = we_wdc | key_hit;
  wire running = (wd_state_reg == TTW_WD_RUN);

  // Error causes, only while running
  wire late    = wd_clk & (wd_cnt_reg == 8'h00) & ~reload;
  wire often   = service & svc_seen_reg & ~wd_clk;
  wire wd_err  = running & (late | often | key_bad);

  // Watchdog start state
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wd_state_reg <= TTW_WD_OFF;
    end else begin
      case (wd_state_reg)
        TTW_WD_OFF: begin
          if (reload) begin
            wd_state_reg <= TTW_WD_RUN;
          end
        end
        TTW_WD_RUN: wd_state_reg <= TTW_WD_RUN;
        default:    wd_state_reg <= TTW_WD_OFF;
      endcase
    end
  end

  // Stored count value
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wdog_reload_count_reg <= `TTW_WDOG_RELOAD_COUNT_RST;
    end else if (we_wdc) begin
      wdog_reload_count_reg <= pwdata[7:0];
    end
  end

  // Watchdog counter; a reload wins over a decrement
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wd_cnt_reg <= `TTW_WDOG_RELOAD_COUNT_RST;
    end else if (we_wdc) begin
      wd_cnt_reg <= pwdata[7:0];
    end else if (key_hit) begin
      wd_cnt_reg <= wdog_reload_count_reg;
    end else if (running & wd_clk & (wd_cnt_reg != 8'h00)) begin
      wd_cnt_reg <= 8'(wd_cnt_reg - 8'h01);
    end
  end

  // Service seen in current watchdog cycle; error pulse
  always_ff @(posedge core_clk) begin
    if (srst) begin
      svc_seen_reg <= 1'b0;
      wd_err_reg   <= 1'b0;
    end else begin
      svc_seen_reg <= service | (svc_seen_reg & ~wd_clk);
      wd_err_reg   <= wd_err;
    end
  end

  // Outputs
  assign prdata         = prdata_reg;
  assign pready         = pready_reg;
  assign pslverr        = pslverr_reg;
  assign tick_out_pulse = tick_out_reg;
  assign tick_irq       = tick_irq_reg;
  assign wdog_reset_req = wd_err_reg;
endmodule

// ### test/ttw_slow_src.sv
`timescale 1ns/100ps
// Slow clock source locked to the fast clock, so tick spacing is exact
module ttw_slow_src #(
  parameter int HALF = 4
) (
  // Fast reference and slow clock out
  input  wire logic core_clk,
  output logic      slow_clk
);
  int cnt = 0;
  initial slow_clk = 1'b0;
  // Toggle every HALF fast cycles; each level lasts over three cycles
  always @(posedge core_clk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) slow_clk <= ~slow_clk;
  end
endmodule

// ### test/ttw_core_sva.sv
`timescale 1ns/100ps
`include "ttw_defs.svh"
module ttw_core_sva
  import ttw_pkg::*;
(
  // Clock and reset
  input wire logic                core_clk,
  input wire logic                srst,
  // Bus
  input wire logic [7:0]          paddr,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  // Device side
  input wire ttw_pkg::ttw_pmode_t pwr_mode,
  input wire logic                tick_out_pulse,
  input wire logic                tick_irq,
  input wire logic                wdog_reset_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Bus handshake
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_once: assert property (pready |=> !pready)
    else $error("pready held");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
  a_mode_refuse: assert property (pready && pwr_mode != TTW_ACTIVE &&
    paddr != `TTW_OFS_WDKEY |-> pslverr) else $error("low power access");
  a_key_open: assert property (pready && paddr == `TTW_OFS_WDKEY |->
    !pslverr) else $error("key refused");
  a_wo_read: assert property (pready && !pwrite &&
    paddr == `TTW_OFS_WDCOUNT |-> prdata == 32'h0) else $error("count read");
  // Timer and watchdog outputs
  a_rst_quiet: assert property ($fell(srst) |-> !wdog_reset_req && !tick_irq)
    else $error("output after reset");
  a_irq_pulse: assert property (tick_irq |-> tick_out_pulse ##1 !tick_irq)
    else $error("irq pulse bad");
  a_tick_hold: assert property ($rose(tick_out_pulse) |=> tick_out_pulse[*4])
    else $error("tick too short");
  a_halt_frozen: assert property ((pwr_mode == TTW_HALT)[*3] |->
    $stable(tick_out_pulse) && !tick_irq) else $error("halt not frozen");
  a_err_pulse: assert property (wdog_reset_req |=> !wdog_reset_req)
    else $error("reset request held");
  c_err: cover property (wdog_reset_req);
  c_irq: cover property (tick_irq);
  c_slverr: cover property (pready && pslverr);
endmodule
bind ttw_core ttw_core_sva chk_u (.core_clk(core_clk), .srst(srst),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pwr_mode(pwr_mode), .tick_out_pulse(tick_out_pulse),
  .tick_irq(tick_irq), .wdog_reset_req(wdog_reset_req));

// ### test/tb_tick_timer_watchdog.sv
`timescale 1ns/100ps
`include "ttw_defs.svh"
module tb_tick_timer_watchdog;
  import ttw_pkg::*;
  logic        core_clk = 1'b0;
  logic        srst     = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        slow_clk;
  logic        tick_out_pulse;
  logic        tick_irq;
  logic        wdog_reset_req;
  logic [33:0] cur;
  logic [15:0] v;
  ttw_pmode_t  pwr_mode = TTW_ACTIVE;
  logic [33:0] exq[$];
  int mismatches = 0;
  int compares = 0;
  int errs = 0;
  int irqs = 0;
  int seed = 18;
  int n, t;
  always #4 core_clk = ~core_clk;
  ttw_core dut_u (.core_clk(core_clk), .srst(srst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_speed_clock(slow_clk), .pwr_mode(pwr_mode),
    .tick_out_pulse(tick_out_pulse), .tick_irq(tick_irq),
    .wdog_reset_req(wdog_reset_req));
  ttw_slow_src #(.HALF(4)) slow_u (.core_clk(core_clk), .slow_clk(slow_clk));
  task final_report;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  task rst;
    @(posedge core_clk);
    srst <= 1'b1;
    pwr_mode <= TTW_ACTIVE;
    cyc(10);
    srst <= 1'b0;
  endtask
  // One bus transfer; the expected answer is queued for the monitor
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [32:0] e);
    exq.push_back({~w, e});
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    // Sample pready at each rising edge; release only after it is seen
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (n == 40) begin
      mismatches++;
      final_report();
    end
    {psel, penable} <= 2'b00;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic er = 1'b0);
    apb(1'b0, a, 32'h0, {er, e});
  endtask
  // Wait for a tick level, counting cycles in t
  task wt(input logic lv);
    for (n = 0; tick_out_pulse !== lv; n++) begin
      if (n > 4000) begin
        mismatches++;
        final_report();
      end
      @(negedge core_clk);
      t++;
    end
  endtask
  task gap;
    repeat (2) begin
      wt(1'b0);
      wt(1'b1);
      t = 0;
    end
    wt(1'b0);
    wt(1'b1);
  endtask
  // Monitor: compare each answer with the oldest queued note
  always @(negedge core_clk) begin
    if (wdog_reset_req === 1'b1) errs++;
    if (tick_irq === 1'b1) irqs++;
    if (pready === 1'b1) begin
      cur = exq.pop_front();
      chk({31'h0, pslverr}, {31'h0, cur[32]});
      if (cur[33]) chk(prdata, cur[31:0]);
    end
  end
  initial begin
    rst();
    rd(`TTW_OFS_CONFIG, 32'h0);
    rd(`TTW_OFS_PRESCALE, 32'h0);
    rd(`TTW_OFS_PERIOD, 32'hFFFF);
    rd(`TTW_OFS_CSR, 32'h0);
    rd(`TTW_OFS_WDCOUNT, 32'h0);
    rd(8'h18, 32'h0, 1'b1);
    repeat (4) begin
      v = 16'($random(seed)) | 16'h0001;
      wr(`TTW_OFS_PERIOD, {16'h0, v});
      rd(`TTW_OFS_PERIOD, {16'h0, v});
    end
    wr(`TTW_OFS_CONFIG, 32'h10);
    wr(`TTW_OFS_CONFIG, 32'h00);
    rd(`TTW_OFS_CONFIG, 32'h10);
    $display("register test done");
    wr(`TTW_OFS_PERIOD, 32'h3);
    wr(`TTW_OFS_CSR, 32'h5);
    irqs = 0;
    for (int c = 0; c < 6; c++) begin
      wr(`TTW_OFS_PRESCALE, 32'(c));
      gap();
      chk(t, 32 << c);
    end
    chk(irqs > 0, 1);
    wr(`TTW_OFS_PRESCALE, 32'h0);
    gap();
    rd(`TTW_OFS_CSR, 32'h6);
    rd(`TTW_OFS_CSR, 32'h4);
    wr(`TTW_OFS_CSR, 32'h0);
    irqs = 0;
    pwr_mode <= TTW_HALT;
    rd(`TTW_OFS_PERIOD, 32'h0, 1'b1);
    cyc(50);
    pwr_mode <= TTW_ACTIVE;
    gap();
    chk(t, 32);
    chk(irqs, 0);
    $display("timer test done");
    chk(errs, 0);
    wr(`TTW_OFS_WDCOUNT, 32'h3);
    cyc(20);
    chk(errs, 0);
    cyc(20);
    chk(errs > 0, 1);
    cyc(40);
    chk(errs > 1, 1);
    rst();
    wr(`TTW_OFS_CONFIG, 32'h10);
    errs = 0;
    wr(`TTW_OFS_WDCOUNT, 32'h3);
    repeat (6) begin
      cyc(10);
      wr(`TTW_OFS_WDCOUNT, 32'h3);
    end
    chk(errs, 0);
    $display("plain service test done");
    rst();
    wr(`TTW_OFS_PRESCALE, 32'h3);
    wr(`TTW_OFS_CONFIG, 32'h30);
    wr(`TTW_OFS_WDCOUNT, 32'h8);
    errs = 0;
    cyc(48);
    pwr_mode <= TTW_PSAVE;
    rd(`TTW_OFS_PERIOD, 32'h0, 1'b1);
    repeat (4) begin
      cyc(100);
      wr(`TTW_OFS_WDKEY, {24'h0, `TTW_SVC_KEY});
    end
    chk(errs, 0);
    // Three quick services: at most one watchdog edge falls among them
    wr(`TTW_OFS_WDKEY, {24'h0, `TTW_SVC_KEY});
    wr(`TTW_OFS_WDKEY, {24'h0, `TTW_SVC_KEY});
    wr(`TTW_OFS_WDKEY, {24'h0, `TTW_SVC_KEY});
    cyc(3);
    chk(errs > 0, 1);
    rst();
    wr(`TTW_OFS_CONFIG, 32'h20);
    wr(`TTW_OFS_WDCOUNT, 32'h8);
    errs = 0;
    wr(`TTW_OFS_WDKEY, 32'h11);
    cyc(3);
    chk(errs > 0, 1);
    rst();
    wr(`TTW_OFS_CONFIG, 32'h10);
    errs = 0;
    wr(`TTW_OFS_WDKEY, 32'h11);
    cyc(300);
    chk(errs, 0);
    $display("key service test done");
    rst();
    wr(`TTW_OFS_CONFIG, 32'h04);
    wr(`TTW_OFS_PERIOD, 32'h55);
    rd(`TTW_OFS_PERIOD, 32'h0);
    rd(`TTW_OFS_CSR, 32'h0);
    wr(`TTW_OFS_PRESCALE, 32'h2);
    rd(`TTW_OFS_PRESCALE, 32'h2);
    wr(`TTW_OFS_CONFIG, 32'h01);
    rd(`TTW_OFS_CONFIG, 32'h0);
    $display("lock test done");
    final_report();
  end
endmodule
